// ===== hw/fhc_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "fhc_regs.svh"
// Notes on behaviour
// R1: polling bit valid after last write strobe
// R2: programming shows inverse of bit seven
// R3: poll program status at programmed address
// R4: protected program target busy about 1 us
// R5: erase polls zero, one when done
// R6: sector erase polls inside selected sector
// R7: chip erase polls unprotected sector
// R8: all protected erase busy about 100 us
// R9: partly protected erase skips protected sectors
// R10: trust whole byte only on later read
// R11: ready/busy low while program or erase
// R12: toggle bit one inverts per read
// R13: toggle one stops in erase suspend
// R14: protected program toggles about 1 us
// R15: toggle two inverts in erased sectors
// R16: chip select or output strobe delimit reads
// R17: two reads, equal toggle means done
// R18: timeout flag set: recheck, else reset
// R19: resume restarts from first double read
// R20: reread polling bit after timeout flag
// R21: timeout flag high marks failed operation
// R22: reset command is F0 anywhere
module fhc_top import fhc_pkg::*; #(
	parameter int ADDR_W      = 20,
	parameter int ASSERT_CYC  = 8,
	parameter int RECOVER_CYC = 4
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic [11:0]       paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic      [ADDR_W-1:0] flash_addr,
	output logic                   flash_ce_n,
	output logic                   flash_oe_n,
	output logic                   flash_we_n,
	input  wire logic [7:0]        data_lines_low_byte_in,
	output logic      [7:0]        data_lines_low_byte_out,
	output logic                   data_lines_low_byte_oe_n,
	input  wire logic              ready_busy_n_out
);
	// ==========================================
	// register decode
	function automatic logic [2:0] fhc_reg_idx(input logic [11:0] a);
		case (a)
			`FHC_OFF_CTRL:  fhc_reg_idx = `FHC_IDX_CTRL;
			`FHC_OFF_ADDR:  fhc_reg_idx = `FHC_IDX_ADDR;
			`FHC_OFF_WDATA: fhc_reg_idx = `FHC_IDX_WDATA;
			`FHC_OFF_STAT:  fhc_reg_idx = `FHC_IDX_STAT;
			`FHC_OFF_RDATA: fhc_reg_idx = `FHC_IDX_RDATA;
			default:        fhc_reg_idx = `FHC_IDX_NONE;
		endcase
	endfunction : fhc_reg_idx
	fhc_state_t        state_q, state_d;
	fhc_op_t           op_q, op_d;
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic [7:0]        wdata_q, wdata_d, prev_q, prev_d, rd_q, rd_d;
	logic [31:0]       prdata_q, prdata_d;
	logic              pend_q, pend_d, done_q, done_d, fail_q, fail_d;
	logic              tfail_q, tfail_d, tog2_q, tog2_d;
	logic              wr_en, setup_rd, start, clr_done, clr_fail;
	logic              set_done, set_fail, set_tfail, set_tog2;
	logic              in_cyc, accept, cdone, tog1_same, poll_match;
	logic [2:0]        idx;
	logic [7:0]        rdat;
	logic [8:0]        sync_q;
	fhc_cyc_if #(.ADDR_W(ADDR_W)) cyc ();
	// ==========================================
	// pin synchronisers
	fhc_sync #(.W(9)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({ready_busy_n_out, data_lines_low_byte_in}),
		.q       (sync_q)
	);
	fhc_cycle #(.ADDR_W(ADDR_W), .ASSERT_CYC(ASSERT_CYC),
		.RECOVER_CYC(RECOVER_CYC)) u_cycle (
		.pclk       (pclk),
		.presetn    (presetn),
		.cyc        (cyc),
		.dq_sync    (sync_q[7:0]),
		.flash_addr (flash_addr),
		.flash_ce_n (flash_ce_n),
		.flash_oe_n (flash_oe_n),
		.flash_we_n (flash_we_n),
		.dq_out     (data_lines_low_byte_out),
		.dq_oe_n    (data_lines_low_byte_oe_n)
	);
	// ==========================================
	// bus slave and cycle requests
	assign idx      = fhc_reg_idx(paddr);
	assign wr_en    = psel && penable && pwrite;
	assign setup_rd = psel && !penable && !pwrite;
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && (idx == `FHC_IDX_NONE);
	assign prdata   = prdata_q;
	assign start    = wr_en && (idx == `FHC_IDX_CTRL) &&
	                  pwdata[`FHC_CTRL_START] && (state_q == S_IDLE);
	assign clr_done = wr_en && (idx == `FHC_IDX_STAT) &&
	                  pwdata[`FHC_STAT_DONE];
	assign clr_fail = wr_en && (idx == `FHC_IDX_STAT) &&
	                  pwdata[`FHC_STAT_FAIL];
	assign in_cyc   = (state_q != S_IDLE) && (state_q != S_FIN);
	assign cyc.req  = in_cyc && !pend_q;
	assign cyc.we   = (state_q == S_WR) || (state_q == S_RST);
	assign cyc.addr = addr_q; // R3 R6 R7
	assign cyc.wdata = (state_q == S_RST) ? `FHC_RESET_CMD : wdata_q; // R22
	assign accept   = cyc.req && cyc.ready;
	assign cdone    = cyc.done;
	assign rdat     = cyc.rdata;
	assign tog1_same = (rdat[`FHC_BIT_TOG1] == prev_q[`FHC_BIT_TOG1]); // R12
	assign poll_match = (rdat[`FHC_BIT_POLL] ==
	                     wdata_q[`FHC_BIT_POLL]); // R2 R5
	// ==========================================
	// registers written by software, read mux
	always_comb begin
		op_d = op_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		prdata_d = prdata_q;
		if (wr_en && (state_q == S_IDLE)) begin
			case (idx)
				`FHC_IDX_CTRL: begin
					op_d = fhc_op_t'(pwdata[`FHC_CTRL_OP_HI:`FHC_CTRL_OP_LO]);
				end
				`FHC_IDX_ADDR:  addr_d = pwdata[ADDR_W-1:0];
				`FHC_IDX_WDATA: wdata_d = pwdata[7:0];
				default: ;
			endcase
		end
		if (setup_rd) begin
			prdata_d = 32'h0000_0000;
			case (idx)
				`FHC_IDX_CTRL: begin
					prdata_d[`FHC_CTRL_OP_HI:`FHC_CTRL_OP_LO] = op_q;
				end
				`FHC_IDX_ADDR:  prdata_d[ADDR_W-1:0] = addr_q;
				`FHC_IDX_WDATA: prdata_d[7:0] = wdata_q;
				`FHC_IDX_STAT: begin
					prdata_d[`FHC_STAT_BUSY] = (state_q != S_IDLE);
					prdata_d[`FHC_STAT_DONE] = done_q;
					prdata_d[`FHC_STAT_FAIL] = fail_q;
					prdata_d[`FHC_STAT_RDY] = sync_q[8]; // R11
					prdata_d[`FHC_STAT_TFAIL] = tfail_q;
					prdata_d[`FHC_STAT_TOG2] = tog2_q;
				end
				`FHC_IDX_RDATA: prdata_d[7:0] = rd_q;
				default: ;
			endcase
		end
	end
	// ==========================================
	// status sequencer
	always_comb begin
		state_d = state_q;
		prev_d = prev_q;
		rd_d = rd_q;
		set_done = 1'b0;
		set_fail = 1'b0;
		set_tfail = 1'b0;
		set_tog2 = 1'b0;
		pend_d = (pend_q || accept) && !cdone;
		case (state_q)
			S_IDLE: begin
				if (start) begin
					case (fhc_op_t'(pwdata[`FHC_CTRL_OP_HI:`FHC_CTRL_OP_LO]))
						FHC_OP_WRITE:  state_d = S_WR;
						FHC_OP_READ:   state_d = S_RD;
						FHC_OP_TOGGLE: state_d = S_TG1;
						default:       state_d = S_DP1;
					endcase
				end
			end
			S_WR: state_d = cdone ? S_FIN : state_q;
			S_RD, S_DP3: begin
				if (cdone) begin
					rd_d = rdat; // R10
					state_d = S_FIN;
				end
			end
			S_TG1: begin
				if (cdone) begin
					prev_d = rdat;
					state_d = S_TG2;
				end
			end
			S_TG2: begin
				if (cdone) begin
					rd_d = rdat;
					prev_d = rdat;
					set_tog2 = (rdat[`FHC_BIT_TOG2] !=
					            prev_q[`FHC_BIT_TOG2]); // R15
					if (tog1_same) begin
						state_d = S_FIN; // R17 R13
					end else if (rdat[`FHC_BIT_TFAIL]) begin
						set_tfail = 1'b1; // R21
						state_d = S_TG3; // R18
					end else begin
						state_d = S_TG1; // R19
					end
				end
			end
			S_TG3: begin
				if (cdone) begin
					rd_d = rdat;
					state_d = tog1_same ? S_FIN : S_RST; // R18
				end
			end
			S_DP1: begin
				if (cdone) begin
					if (poll_match) begin
						state_d = S_DP3; // R10
					end else if (rdat[`FHC_BIT_TFAIL]) begin
						set_tfail = 1'b1; // R21
						state_d = S_DP2; // R20
					end
				end
			end
			S_DP2: begin
				if (cdone) begin
					state_d = poll_match ? S_DP3 : S_RST; // R20
				end
			end
			S_RST: begin
				if (cdone) begin
					set_fail = 1'b1;
					state_d = S_FIN;
				end
			end
			S_FIN: begin
				set_done = 1'b1;
				state_d = S_IDLE;
			end
			default: state_d = S_IDLE;
		endcase
		done_d = set_done || (done_q && !clr_done);
		fail_d = set_fail || (fail_q && !clr_fail);
		tfail_d = set_tfail || (tfail_q && !start);
		tog2_d = set_tog2 || (tog2_q && !start);
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= S_IDLE;
			op_q <= FHC_OP_WRITE;
			addr_q <= '0;
			wdata_q <= 8'h00;
			prev_q <= 8'h00;
			rd_q <= 8'h00;
			prdata_q <= 32'h0000_0000;
			pend_q <= 1'b0;
			done_q <= 1'b0;
			fail_q <= 1'b0;
			tfail_q <= 1'b0;
			tog2_q <= 1'b0;
		end else begin
			state_q <= state_d;
			op_q <= op_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			prev_q <= prev_d;
			rd_q <= rd_d;
			prdata_q <= prdata_d;
			pend_q <= pend_d;
			done_q <= done_d;
			fail_q <= fail_d;
			tfail_q <= tfail_d;
			tog2_q <= tog2_d;
		end
	end
	// ==========================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_tg2_end;
		(state_q == S_TG2) && cdone;
	endsequence
	sequence s_dp1_end;
		(state_q == S_DP1) && cdone;
	endsequence
	property p_poll_addr;
		((state_q == S_DP1) || (state_q == S_DP2)) && !flash_ce_n
		|-> (flash_addr == addr_q);
	endproperty
	a_poll_addr: assert property (p_poll_addr) // R3
		else $error("poll read at wrong address");
	property p_tg_done;
		s_tg2_end ##0 tog1_same |=> (state_q == S_FIN) ##1 done_q;
	endproperty
	a_tg_done: assert property (p_tg_done) // R17
		else $error("stable toggle not reported done");
	property p_tg_restart;
		s_tg2_end ##0 (!tog1_same && !rdat[`FHC_BIT_TFAIL])
		|=> (state_q == S_TG1);
	endproperty
	a_tg_restart: assert property (p_tg_restart) // R19
		else $error("toggle check not restarted");
	property p_tg_fail;
		(state_q == S_TG3) && cdone && !tog1_same |=> (state_q == S_RST)
		##[1:60] ((state_q == S_FIN) && fail_d);
	endproperty
	a_tg_fail: assert property (p_tg_fail) // R18
		else $error("toggle failure without reset");
	property p_dp_reread;
		s_dp1_end ##0 (!poll_match && rdat[`FHC_BIT_TFAIL])
		|=> (state_q == S_DP2);
	endproperty
	a_dp_reread: assert property (p_dp_reread) // R20
		else $error("polling bit not reread");
	property p_dp_final;
		s_dp1_end ##0 poll_match |=> (state_q == S_DP3) && !done_q;
	endproperty
	a_dp_final: assert property (p_dp_final) // R10
		else $error("no confirming read after poll");
	property p_rst_cmd;
		(state_q == S_RST) && accept |=> !flash_ce_n && !flash_we_n &&
		(data_lines_low_byte_out == `FHC_RESET_CMD) &&
		!data_lines_low_byte_oe_n;
	endproperty
	a_rst_cmd: assert property (p_rst_cmd) // R22
		else $error("reset command not driven");
	property p_done_wins;
		set_done && clr_done |=> done_q;
	endproperty
	a_done_wins: assert property (p_done_wins) // R17
		else $error("done lost under clear");
endmodule : fhc_top
`default_nettype wire

// ===== hw/fhc_regs.svh
`ifndef FHC_REGS_SVH
`define FHC_REGS_SVH
// ==========================================
// register map of the host controller
`define FHC_OFF_CTRL    12'h000
`define FHC_OFF_ADDR    12'h004
`define FHC_OFF_WDATA   12'h008
`define FHC_OFF_STAT    12'h00c
`define FHC_OFF_RDATA   12'h010
`define FHC_IDX_CTRL    3'h0
`define FHC_IDX_ADDR    3'h1
`define FHC_IDX_WDATA   3'h2
`define FHC_IDX_STAT    3'h3
`define FHC_IDX_RDATA   3'h4
`define FHC_IDX_NONE    3'h7
// ==========================================
// field positions
`define FHC_CTRL_START  0
`define FHC_CTRL_OP_LO  1
`define FHC_CTRL_OP_HI  2
`define FHC_STAT_BUSY   0
`define FHC_STAT_DONE   1
`define FHC_STAT_FAIL   2
`define FHC_STAT_RDY    3
`define FHC_STAT_TFAIL  4
`define FHC_STAT_TOG2   5
// ==========================================
// status bits on the flash data byte
`define FHC_BIT_POLL    7
`define FHC_BIT_TOG1    6
`define FHC_BIT_TFAIL   5
`define FHC_BIT_TOG2    2
`define FHC_RESET_CMD   8'hf0
`define FHC_SYNC_STAGES 2
`endif

// ===== hw/fhc_pkg.sv
// ==========================================
// types of the host controller
package fhc_pkg;
	typedef enum logic [1:0] {
		FHC_OP_WRITE = 2'h0,
		FHC_OP_READ  = 2'h1,
		FHC_OP_TOGGLE = 2'h2,
		FHC_OP_DPOLL = 2'h3
	} fhc_op_t;
	typedef enum logic [3:0] {
		S_IDLE = 4'h0, S_WR  = 4'h1, S_RD  = 4'h3, S_TG1 = 4'h2,
		S_TG2  = 4'h6, S_TG3 = 4'h7, S_DP1 = 4'h5, S_DP2 = 4'h4,
		S_DP3  = 4'hc, S_RST = 4'hd, S_FIN = 4'hf
	} fhc_state_t;
	typedef enum logic [1:0] {
		E_IDLE = 2'h0, E_ACT = 2'h1, E_REC = 2'h3
	} fhc_eng_t;
endpackage : fhc_pkg

// ===== hw/fhc_cyc_if.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// one flash bus cycle request and its answer
interface fhc_cyc_if #(parameter int ADDR_W = 20);
	logic              req;
	logic              ready;
	logic              we;
	logic [ADDR_W-1:0] addr;
	logic [7:0]        wdata;
	logic [7:0]        rdata;
	logic              done;
	modport master (output req, we, addr, wdata, input ready, rdata, done);
	modport engine (input req, we, addr, wdata, output ready, rdata, done);
endinterface : fhc_cyc_if
`default_nettype wire

// ===== hw/fhc_sync.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// two-stage synchroniser per bit
module fhc_sync #(parameter int W = 9) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic s1_q;
			logic s2_q;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					s1_q <= 1'b1;
					s2_q <= 1'b1;
				end else begin
					s1_q <= d[i];
					s2_q <= s1_q;
				end
			end
			assign q[i] = s2_q;
		end
	endgenerate
endmodule : fhc_sync
`default_nettype wire

// ===== hw/fhc_cycle.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// flash bus cycle engine
module fhc_cycle import fhc_pkg::*; #(
	parameter int ADDR_W      = 20,
	parameter int ASSERT_CYC  = 8,
	parameter int RECOVER_CYC = 4
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	fhc_cyc_if.engine              cyc,
	input  wire logic [7:0]        dq_sync,
	output logic      [ADDR_W-1:0] flash_addr,
	output logic                   flash_ce_n,
	output logic                   flash_oe_n,
	output logic                   flash_we_n,
	output logic      [7:0]        dq_out,
	output logic                   dq_oe_n
);
	localparam logic [7:0] ACT_LAST = 8'(ASSERT_CYC - 1);
	localparam logic [7:0] REC_LAST = 8'(RECOVER_CYC - 1);
	localparam int T_DONE = ASSERT_CYC + RECOVER_CYC + 1;
	fhc_eng_t          st_q, st_d;
	logic [7:0]        cnt_q, cnt_d, rd_q, rd_d, wd_q, wd_d;
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic              we_q, we_d, done_q, done_d;
	logic              ce_q, ce_d, oe_q, oe_d, wen_q, wen_d, doe_q, doe_d;
	// ==========================================
	// next state
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q + 8'h01;
		rd_d = rd_q;
		wd_d = wd_q;
		addr_d = addr_q;
		we_d = we_q;
		done_d = 1'b0;
		ce_d = ce_q;
		oe_d = oe_q;
		wen_d = wen_q;
		doe_d = doe_q;
		case (st_q)
			E_IDLE: begin
				cnt_d = 8'h00;
				if (cyc.req) begin
					st_d = E_ACT;
					we_d = cyc.we;
					addr_d = cyc.addr;
					wd_d = cyc.wdata;
					ce_d = 1'b0; // R16
					oe_d = cyc.we;
					wen_d = ~cyc.we;
					doe_d = ~cyc.we;
				end
			end
			E_ACT: begin
				if (cnt_q == ACT_LAST) begin
					st_d = E_REC;
					cnt_d = 8'h00;
					ce_d = 1'b1; // R16
					oe_d = 1'b1;
					wen_d = 1'b1;
					if (!we_q) begin
						rd_d = dq_sync;
					end
				end
			end
			E_REC: begin
				doe_d = 1'b1;
				if (cnt_q == REC_LAST) begin
					st_d = E_IDLE;
					done_d = 1'b1;
				end
			end
			default: begin
				st_d = E_IDLE;
			end
		endcase
	end
	// ==========================================
	// registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= E_IDLE;
			cnt_q <= 8'h00;
			rd_q <= 8'h00;
			wd_q <= 8'h00;
			addr_q <= '0;
			we_q <= 1'b0;
			done_q <= 1'b0;
			ce_q <= 1'b1;
			oe_q <= 1'b1;
			wen_q <= 1'b1;
			doe_q <= 1'b1;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			rd_q <= rd_d;
			wd_q <= wd_d;
			addr_q <= addr_d;
			we_q <= we_d;
			done_q <= done_d;
			ce_q <= ce_d;
			oe_q <= oe_d;
			wen_q <= wen_d;
			doe_q <= doe_d;
		end
	end
	assign cyc.ready  = (st_q == E_IDLE);
	assign cyc.done   = done_q;
	assign cyc.rdata  = rd_q;
	assign flash_addr = addr_q;
	assign flash_ce_n = ce_q;
	assign flash_oe_n = oe_q;
	assign flash_we_n = wen_q;
	assign dq_out     = wd_q;
	assign dq_oe_n    = doe_q;
	// ==========================================
	// checks
	property p_cyc_time;
		@(posedge pclk) disable iff (!presetn)
		(cyc.req && cyc.ready) |-> ##[T_DONE:T_DONE] cyc.done;
	endproperty
	a_cyc_time: assert property (p_cyc_time) // R16
		else $error("cycle answer late or early");
	property p_read_in_ce;
		@(posedge pclk) disable iff (!presetn)
		!flash_oe_n |-> (!flash_ce_n && flash_we_n && dq_oe_n);
	endproperty
	a_read_in_ce: assert property (p_read_in_ce) // R16
		else $error("read strobe outside chip select");
endmodule : fhc_cycle
`default_nettype wire

// ===== testbench/fhc_flash_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// behavioural flash device on the parallel bus
module fhc_flash_model #(parameter int PROG_READS = 4) (
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic [19:0] addr,
	input  wire logic [7:0]  host_dq,
	input  wire logic        host_oe_n,
	input  wire logic        prot,
	input  wire logic        fail_mode,
	input  wire logic        erase_req,
	output logic      [7:0]  dq,
	output logic             ry_n
);
	logic [7:0]  mem [logic [19:0]];
	logic [19:0] pa = 20'h0;
	logic [7:0]  wd = 8'h0;
	logic [7:0]  last = 8'h0;
	logic [7:0]  drv;
	logic        busy = 1'b0;
	logic        er = 1'b0;
	logic        tg1 = 1'b0;
	logic        tg2 = 1'b0;
	logic        fl = 1'b0;
	logic        pr = 1'b0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	int          left = 0;
	task automatic start(input logic e);
		busy = 1'b1;
		er = e;
		left = PROG_READS;
		fl = fail_mode;
		pr = prot;
	endtask : start
	always @(posedge erase_req) start(1'b1);
	always @(negedge ce_n or negedge oe_n or negedge we_n) begin
		if (!ce_n && !oe_n) rd = 1'b1;
		if (!ce_n && !we_n) wr = 1'b1;
	end
	always @(posedge ce_n or posedge oe_n or posedge we_n) begin
		if (wr) begin
			wr = 1'b0;
			last = host_dq;
			if (host_dq == 8'hf0) begin
				busy = 1'b0;
				fl = 1'b0;
			end else if (!busy) begin
				pa = addr;
				wd = host_dq;
				start(1'b0);
			end
		end
		if (rd) begin
			rd = 1'b0;
			last = drv;
			if (busy) begin
				tg1 = ~tg1;
				tg2 = tg2 ^ er;
				if (!fl) left--;
				if (left == 0) begin
					busy = 1'b0;
					// protected target left untouched
					if (pr) last = drv;
					else if (er) mem.delete();
					else mem[pa] = wd;
				end
			end
		end
	end
	// status byte while busy, array data otherwise
	always @* begin
		if (busy) drv = {~er & ~wd[7], tg1, fl, 1'b0, er, er & tg2, 2'b00};
		else drv = mem.exists(addr) ? mem[addr] : 8'hff;
	end
	assign dq = !host_oe_n ? host_dq : (!ce_n && !oe_n) ? drv : ~last;
	assign ry_n = busy ? 1'b0 : 1'b1;
endmodule : fhc_flash_model
`default_nettype wire

// ===== testbench/fhc_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "fhc_regs.svh"
// ==========================================
// bench for the flash host controller
module fhc_top_tb_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [19:0] faddr;
	logic [7:0]  dq_o, dq_i;
	logic        ce_n, oe_n, we_n, dq_oe_n, ryn, prot, fmode, ereq, e;
	int          error_cnt, total_checks;
	fhc_top #(.ADDR_W(20)) DUT (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .flash_addr(faddr), .flash_ce_n(ce_n),
		.flash_oe_n(oe_n), .flash_we_n(we_n),
		.data_lines_low_byte_in(dq_i), .data_lines_low_byte_out(dq_o),
		.data_lines_low_byte_oe_n(dq_oe_n), .ready_busy_n_out(ryn));
	fhc_flash_model FLASH (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
		.addr(faddr), .host_dq(dq_o), .host_oe_n(dq_oe_n), .prot(prot),
		.fail_mode(fmode), .erase_req(ereq), .dq(dq_i), .ry_n(ryn));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// ==========================================
	// tasks
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict
	task automatic cmp32(input string nm, input logic [31:0] x,
		input logic [31:0] g);
		total_checks++;
		if (g !== x) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, x, g);
		end
	endtask : cmp32
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic er);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) print_verdict_err();
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic print_verdict_err();
		error_cnt++;
		print_verdict();
	endtask : print_verdict_err
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, r, e);
	endtask : wr
	task automatic chk(input string nm, input logic [11:0] a,
		input logic [31:0] x);
		apb(1'b0, a, 32'h0, r, e);
		cmp32(nm, x, r);
	endtask : chk
	task automatic run_op(input logic [1:0] op, input logic [19:0] a,
		input logic [7:0] d);
		int n;
		wr(`FHC_OFF_STAT, 32'h6);
		wr(`FHC_OFF_ADDR, {12'h0, a});
		wr(`FHC_OFF_WDATA, {24'h0, d});
		wr(`FHC_OFF_CTRL, {29'h0, op, 1'b1});
		n = 0;
		do begin
			apb(1'b0, `FHC_OFF_STAT, 32'h0, r, e);
			n++;
		end while (r[`FHC_STAT_DONE] !== 1'b1 && n < 500);
		if (n >= 500) print_verdict_err();
	endtask : run_op
	// ==========================================
	// main sequence
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		prot = 1'b0;
		fmode = 1'b0;
		ereq = 1'b0;
		presetn = 1'b0;
		error_cnt = 0;
		total_checks = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		chk("stat_reset", `FHC_OFF_STAT, 32'h8);
		apb(1'b0, 12'h100, 32'h0, r, e);
		cmp32("unmapped_err", 32'h1, {31'h0, e});
		cmp32("unmapped_data", 32'h0, r);
		run_op(2'h0, 20'h00010, 8'h5a);
		run_op(2'h2, 20'h00010, 8'h00);
		chk("stat_toggle", `FHC_OFF_STAT, 32'ha);
		run_op(2'h1, 20'h00010, 8'h00);
		chk("rdata_read", `FHC_OFF_RDATA, 32'h5a);
		run_op(2'h0, 20'h00020, 8'ha5);
		run_op(2'h3, 20'h00020, 8'ha5);
		chk("stat_poll", `FHC_OFF_STAT, 32'ha);
		chk("rdata_poll", `FHC_OFF_RDATA, 32'ha5);
		prot <= 1'b1;
		run_op(2'h0, 20'h00030, 8'h00);
		run_op(2'h2, 20'h00030, 8'h00);
		prot <= 1'b0;
		chk("stat_prot", `FHC_OFF_STAT, 32'ha);
		run_op(2'h1, 20'h00030, 8'h00);
		chk("rdata_prot", `FHC_OFF_RDATA, 32'hff);
		ereq <= 1'b1;
		run_op(2'h3, 20'h00010, 8'hff);
		ereq <= 1'b0;
		chk("stat_erase", `FHC_OFF_STAT, 32'ha);
		chk("rdata_erase", `FHC_OFF_RDATA, 32'hff);
		ereq <= 1'b1;
		run_op(2'h2, 20'h00010, 8'h00);
		ereq <= 1'b0;
		chk("stat_erase_tog", `FHC_OFF_STAT, 32'h2a);
		fmode <= 1'b1;
		for (int k = 2; k < 4; k++) begin
			run_op(2'h0, 20'h00040, 8'h11);
			run_op(k[1:0], 20'h00040, 8'h11);
			chk("stat_fail", `FHC_OFF_STAT, 32'h1e);
		end
		fmode <= 1'b0;
		run_op(2'h1, 20'h00040, 8'h00);
		chk("rdata_after_reset", `FHC_OFF_RDATA, 32'hff);
		print_verdict();
	end
endmodule : fhc_top_tb_top
`default_nettype wire
